// file: rtl/bcrb_pkg.sv
// Purpose: constants and carrier types for the burner configuration register bank
// Assumes: 250 MHz clock, 16-bit holding registers numbered 0 to 20
// Notes: reset values and limits are shared by the bank and its write checker
package bcrb_pkg;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam longint unsigned SECOND_PS = 64'd1000000000000;
    localparam int unsigned TICKS_PER_SEC = int'(SECOND_PS / CLK_PERIOD_PS);

    // --------------------------------------------------------------
    // register numbers
    // --------------------------------------------------------------
    localparam logic [15:0] REG_VERSION = 16'h0001;
    localparam logic [15:0] REG_REVISION = 16'h0002;
    localparam logic [15:0] REG_CRC_UPPER = 16'h0003;
    localparam logic [15:0] REG_CRC_LOWER = 16'h0004;
    localparam logic [15:0] REG_MODE = 16'h0005;
    localparam logic [15:0] REG_PREPURGE = 16'h0006;
    localparam logic [15:0] REG_IGNITE = 16'h0007;
    localparam logic [15:0] REG_INTERPURGE = 16'h0008;
    localparam logic [15:0] REG_HOLD = 16'h0009;
    localparam logic [15:0] REG_IGN_RETRY = 16'h000a;
    localparam logic [15:0] REG_HOLD_RETRY = 16'h000b;
    localparam logic [15:0] REG_PROVE = 16'h000c;
    localparam logic [15:0] REG_DEMAND = 16'h000d;
    localparam logic [15:0] REG_LIMIT = 16'h000e;
    localparam logic [15:0] REG_P1_SRC = 16'h0014;
    localparam logic [15:0] REG_LAST = 16'h0014;

    // --------------------------------------------------------------
    // accepted ranges (all minimums zero except the limit)
    // --------------------------------------------------------------
    localparam logic [15:0] MODE_MAX = 16'h0001;
    localparam logic [15:0] PREPURGE_MAX = 16'h0258;
    localparam logic [15:0] IGNITE_MAX = 16'h003c;
    localparam logic [15:0] INTERPURGE_MAX = 16'h000a;
    localparam logic [15:0] HOLD_MAX = 16'h0708;
    localparam logic [15:0] RETRY_MAX = 16'h0003;
    localparam logic [15:0] PROVE_MAX = 16'h0005;
    localparam logic [15:0] DEMAND_MAX = 16'h0001;
    localparam logic [15:0] LIMIT_MIN = 16'h0064;
    localparam logic [15:0] LIMIT_MAX = 16'h099c;
    localparam logic [15:0] SRC_MAX = 16'h0004;
    localparam logic [15:0] MODE_AUTO = 16'h0000;

    // --------------------------------------------------------------
    // answer codes
    // --------------------------------------------------------------
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;

    typedef enum logic [15:0] {
        SRC_NONE = 16'h0000,
        SRC_FIRST_THERMOCOUPLE = 16'h0001,
        SRC_SECOND_THERMOCOUPLE = 16'h0002,
        SRC_BURNER_THERMOCOUPLE = 16'h0003,
        SRC_TRANSDUCER_INPUT = 16'h0004
    } bcrb_src_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bcrb_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [15:0] rdata;
    } bcrb_rsp_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] prepurge;
        logic [15:0] ignite;
        logic [15:0] interpurge;
        logic [15:0] hold;
        logic [15:0] ign_retry;
        logic [15:0] hold_retry;
        logic [15:0] prove;
        logic [15:0] demand;
        logic [15:0] limit;
        logic [15:0] p1_src;
    } bcrb_cfg_t;

    localparam bcrb_cfg_t CFG_RST = '{
        mode: 16'h0000, prepurge: 16'h0005, ignite: 16'h001e, interpurge: 16'h000a,
        hold: 16'h0000, ign_retry: 16'h0002, hold_retry: 16'h0002, prove: 16'h0003,
        demand: 16'h0000, limit: 16'h0640, p1_src: 16'h0004
    };

endpackage

// file: rtl/bcrb_wr_check.sv
// Purpose: decides whether a holding-register write may be stored
// Assumes: register numbers as in the package
// Notes: purely combinational
`timescale 1ns/1ps
module bcrb_wr_check import bcrb_pkg::*; (
    input logic [15:0] ADDR,
    input logic [15:0] DATA,
    output logic MAPPED,
    output logic WRITABLE,
    output logic IN_RANGE
);
    logic [15:0] lo;
    logic [15:0] hi;
    logic sgn;

    always_comb begin
        lo = 16'h0000;
        hi = 16'h0000;
        sgn = 1'b0;
        WRITABLE = 1'b1;
        unique case (ADDR)
            REG_MODE: hi = MODE_MAX;
            REG_PREPURGE: hi = PREPURGE_MAX;
            REG_IGNITE: hi = IGNITE_MAX;
            REG_INTERPURGE: hi = INTERPURGE_MAX;
            REG_HOLD: hi = HOLD_MAX;
            REG_IGN_RETRY, REG_HOLD_RETRY: hi = RETRY_MAX;
            REG_PROVE: hi = PROVE_MAX;
            REG_DEMAND: hi = DEMAND_MAX;
            REG_LIMIT: begin
                lo = LIMIT_MIN;
                hi = LIMIT_MAX;
                sgn = 1'b1;
            end
            REG_P1_SRC: hi = SRC_MAX;
            default: WRITABLE = 1'b0;
        endcase
    end

    assign MAPPED = ADDR <= REG_LAST;
    // signed compare keeps negative words out of the limit
    assign IN_RANGE = sgn ? ($signed(DATA) >= $signed(lo) && $signed(DATA) <= $signed(hi))
                          : (DATA >= lo && DATA <= hi);

endmodule // bcrb_wr_check

// file: rtl/bcrb_prove_timer.sv
// Purpose: proves the pilot flame over a whole number of seconds
// Assumes: flame and trial inputs synchronous to CLK
// Notes: any gap in flame restarts the count
`timescale 1ns/1ps
module bcrb_prove_timer import bcrb_pkg::*; #(
    parameter int unsigned TICKS = TICKS_PER_SEC
) (
    input logic CLK,
    input logic RST_N,
    input logic TRIAL,
    input logic FLAME,
    input logic [15:0] PROVE_SECS,
    output logic LIT
);
    typedef struct packed {
        logic [31:0] tick;
        logic [2:0] secs;
        logic lit;
    } bcrb_tmr_t;

    bcrb_tmr_t s_r;
    bcrb_tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!(TRIAL && FLAME)) begin
            s_nxt = '0;
        end else if ({13'h0000, s_r.secs} >= PROVE_SECS) begin
            s_nxt.lit = 1'b1;
        end else if (s_r.tick == TICKS - 1) begin
            s_nxt.tick = 32'h00000000;
            s_nxt.secs = s_r.secs + 3'h1;
        end else begin
            s_nxt.tick = s_r.tick + 32'h00000001;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign LIT = s_r.lit;

    lit_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(LIT) |-> $past(TRIAL && FLAME) && {13'h0000, $past(s_r.secs)} >= $past(PROVE_SECS))
        else $error("pilot lit before flame proven");

endmodule // bcrb_prove_timer

// file: rtl/bcrb_reg_bank.sv
// Purpose: configuration holding registers 0 to 20 of the burner controller
// Assumes: fieldbus framing done outside; one word request per cycle at most
// Notes: answers one cycle after each request
`timescale 1ns/1ps
module bcrb_reg_bank import bcrb_pkg::*; #(
    parameter logic [15:0] FW_VERSION = 16'h0100, // arbitrary value
    parameter logic [15:0] FW_REVISION = 16'h0001, // arbitrary value
    parameter logic [31:0] FW_CHECKSUM = 32'h1234abcd, // arbitrary value
    parameter int unsigned TICKS = TICKS_PER_SEC
) (
    input logic CLK,
    input logic RST_N,
    input bcrb_req_t REQ,
    output bcrb_rsp_t RSP,
    output bcrb_cfg_t CFG,
    input logic PILOT_TRIAL,
    input logic FLAME_SENSED,
    output logic PILOT_LIT,
    output logic DEMAND_PILOT_ACTIVE,
    input logic LOCKOUT_CLEAR,
    output logic HIGH_TEMP_LOCKOUT,
    input logic [15:0] FIRST_THERMOCOUPLE,
    input logic [15:0] SECOND_THERMOCOUPLE,
    input logic [15:0] BURNER_THERMOCOUPLE,
    input logic [15:0] TRANSDUCER_INPUT,
    output logic [15:0] PROCESS1_VALUE
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        bcrb_cfg_t cfg;
        bcrb_rsp_t rsp;
        logic lockout;
        logic demand_act;
        logic [15:0] p1_value;
    } bcrb_state_t;

    bcrb_state_t s_r;
    bcrb_state_t s_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n_s;
    logic mapped;
    logic writable;
    logic in_range;
    logic over_temp;
    logic [15:0] rd_word;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n_s = rst_sync_r[1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    bcrb_wr_check u_wr_check (
        .ADDR(REQ.addr),
        .DATA(REQ.wdata),
        .MAPPED(mapped),
        .WRITABLE(writable),
        .IN_RANGE(in_range)
    );

    bcrb_prove_timer #(
        .TICKS(TICKS)
    ) u_prove_timer (
        .CLK(CLK),
        .RST_N(rst_n_s),
        .TRIAL(PILOT_TRIAL),
        .FLAME(FLAME_SENSED),
        .PROVE_SECS(s_r.cfg.prove),
        .LIT(PILOT_LIT)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        unique case (REQ.addr)
            REG_VERSION: rd_word = FW_VERSION;
            REG_REVISION: rd_word = FW_REVISION;
            REG_CRC_UPPER: rd_word = FW_CHECKSUM[31:16];
            REG_CRC_LOWER: rd_word = FW_CHECKSUM[15:0];
            REG_MODE: rd_word = s_r.cfg.mode;
            REG_PREPURGE: rd_word = s_r.cfg.prepurge;
            REG_IGNITE: rd_word = s_r.cfg.ignite;
            REG_INTERPURGE: rd_word = s_r.cfg.interpurge;
            REG_HOLD: rd_word = s_r.cfg.hold;
            REG_IGN_RETRY: rd_word = s_r.cfg.ign_retry;
            REG_HOLD_RETRY: rd_word = s_r.cfg.hold_retry;
            REG_PROVE: rd_word = s_r.cfg.prove;
            REG_DEMAND: rd_word = s_r.cfg.demand;
            REG_LIMIT: rd_word = s_r.cfg.limit;
            REG_P1_SRC: rd_word = s_r.cfg.p1_src;
            default: rd_word = 16'h0000;
        endcase
    end

    assign over_temp = $signed(BURNER_THERMOCOUPLE) > $signed(s_r.cfg.limit);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.valid = 1'b0;
        if (REQ.valid) begin
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.exc = EXC_NONE;
            s_nxt.rsp.rdata = 16'h0000;
            if (!mapped) begin
                s_nxt.rsp.exc = EXC_ADDR;
            end else if (!REQ.write) begin
                s_nxt.rsp.rdata = rd_word;
            end else if (!writable) begin
                // identity words and unused numbers keep their value
                s_nxt.rsp.exc = EXC_ADDR;
            end else if (!in_range) begin
                s_nxt.rsp.exc = EXC_DATA;
            end else begin
                s_nxt.rsp.rdata = REQ.wdata;
                unique case (REQ.addr)
                    REG_MODE: s_nxt.cfg.mode = REQ.wdata;
                    REG_PREPURGE: s_nxt.cfg.prepurge = REQ.wdata;
                    REG_IGNITE: s_nxt.cfg.ignite = REQ.wdata;
                    REG_INTERPURGE: s_nxt.cfg.interpurge = REQ.wdata;
                    REG_HOLD: s_nxt.cfg.hold = REQ.wdata;
                    REG_IGN_RETRY: s_nxt.cfg.ign_retry = REQ.wdata;
                    REG_HOLD_RETRY: s_nxt.cfg.hold_retry = REQ.wdata;
                    REG_PROVE: s_nxt.cfg.prove = REQ.wdata;
                    REG_DEMAND: s_nxt.cfg.demand = REQ.wdata;
                    REG_LIMIT: s_nxt.cfg.limit = REQ.wdata;
                    REG_P1_SRC: s_nxt.cfg.p1_src = REQ.wdata;
                    default: s_nxt.rsp.exc = EXC_ADDR;
                endcase
            end
        end
        // pilot on demand only in automatic mode
        s_nxt.demand_act = s_r.cfg.demand[0] && s_r.cfg.mode == MODE_AUTO;
        // a fresh excess beats a clear in the same cycle
        s_nxt.lockout = over_temp || (s_r.lockout && !LOCKOUT_CLEAR);
        unique case (s_r.cfg.p1_src)
            SRC_FIRST_THERMOCOUPLE: s_nxt.p1_value = FIRST_THERMOCOUPLE;
            SRC_SECOND_THERMOCOUPLE: s_nxt.p1_value = SECOND_THERMOCOUPLE;
            SRC_BURNER_THERMOCOUPLE: s_nxt.p1_value = BURNER_THERMOCOUPLE;
            SRC_TRANSDUCER_INPUT: s_nxt.p1_value = TRANSDUCER_INPUT;
            default: s_nxt.p1_value = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            s_r.cfg <= CFG_RST;
            s_r.rsp <= '0;
            s_r.lockout <= 1'b0;
            s_r.demand_act <= 1'b0;
            s_r.p1_value <= 16'h0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign RSP = s_r.rsp;
    assign CFG = s_r.cfg;
    assign DEMAND_PILOT_ACTIVE = s_r.demand_act;
    assign HIGH_TEMP_LOCKOUT = s_r.lockout;
    assign PROCESS1_VALUE = s_r.p1_value;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n_s);

    logic rd_req;
    logic wr_req;
    assign rd_req = REQ.valid && !REQ.write;
    assign wr_req = REQ.valid && REQ.write;

    ver_read_a: assert property (
        rd_req && REQ.addr == REG_VERSION |=> RSP.valid && RSP.rdata == FW_VERSION && RSP.exc == EXC_NONE)
        else $error("version word wrong");

    ver_write_a: assert property (
        wr_req && REQ.addr == REG_VERSION
        |=> RSP.exc == EXC_ADDR && RSP.rdata == 16'h0000 && $stable(CFG))
        else $error("version word write not refused");

    rev_read_a: assert property (
        rd_req && REQ.addr == REG_REVISION |=> RSP.rdata == FW_REVISION)
        else $error("revision word wrong");

    crc_upper_a: assert property (
        rd_req && REQ.addr == REG_CRC_UPPER |=> RSP.rdata == FW_CHECKSUM[31:16])
        else $error("checksum upper word wrong");

    crc_lower_a: assert property (
        rd_req && REQ.addr == REG_CRC_LOWER |=> RSP.rdata == FW_CHECKSUM[15:0])
        else $error("checksum lower word wrong");

    ignite_range_a: assert property (
        CFG.ignite <= IGNITE_MAX)
        else $error("ignition time out of range");

    purge_range_a: assert property (
        CFG.interpurge <= INTERPURGE_MAX)
        else $error("purge time out of range");

    hold_range_a: assert property (
        wr_req && REQ.addr == REG_HOLD && REQ.wdata > HOLD_MAX |=> $stable(CFG.hold) && RSP.exc == EXC_DATA)
        else $error("wait time took bad value");

    retry_range_a: assert property (
        CFG.ign_retry <= RETRY_MAX)
        else $error("ignition retries out of range");

    hold_retry_a: assert property (
        wr_req && REQ.addr == REG_HOLD_RETRY && REQ.wdata <= RETRY_MAX
        |=> CFG.hold_retry == $past(REQ.wdata) && RSP.exc == EXC_NONE)
        else $error("wait retries not stored");

    demand_gate_a: assert property (
        CFG.mode != MODE_AUTO ##1 CFG.mode != MODE_AUTO |-> !DEMAND_PILOT_ACTIVE)
        else $error("pilot on demand in manual mode");

    lockout_set_a: assert property (
        $signed(BURNER_THERMOCOUPLE) > $signed(CFG.limit) |=> HIGH_TEMP_LOCKOUT)
        else $error("over temperature without lockout");

    src_mux_a: assert property (
        CFG.p1_src == SRC_TRANSDUCER_INPUT |=> PROCESS1_VALUE == $past(TRANSDUCER_INPUT))
        else $error("process 1 source not followed");

    prepurge_range_a: assert property (
        CFG.prepurge <= PREPURGE_MAX)
        else $error("pre-purge time out of range");

    unused_zero_a: assert property (
        rd_req && REQ.addr > REG_LIMIT && REQ.addr < REG_P1_SRC |=> RSP.rdata == 16'h0000 && RSP.exc == EXC_NONE)
        else $error("unused register not zero");

    // ----------------------------------------------------------------
    // stored values, refusals and outputs
    // ----------------------------------------------------------------
    ign_store_a: assert property (
        wr_req && REQ.addr == REG_IGNITE && REQ.wdata <= IGNITE_MAX |=> CFG.ignite == $past(REQ.wdata))
        else $error("ignition time not stored");

    purge_store_a: assert property (
        wr_req && REQ.addr == REG_INTERPURGE && REQ.wdata <= INTERPURGE_MAX |=> CFG.interpurge == $past(REQ.wdata))
        else $error("purge time not stored");

    hold_store_a: assert property (
        wr_req && REQ.addr == REG_HOLD && REQ.wdata <= HOLD_MAX |=> CFG.hold == $past(REQ.wdata))
        else $error("wait time not stored");

    retry_store_a: assert property (
        wr_req && REQ.addr == REG_IGN_RETRY && REQ.wdata <= RETRY_MAX |=> CFG.ign_retry == $past(REQ.wdata))
        else $error("ignition retries not stored");

    hold_retry_range_a: assert property (
        CFG.hold_retry <= RETRY_MAX)
        else $error("wait retries out of range");

    prove_store_a: assert property (
        wr_req && REQ.addr == REG_PROVE && REQ.wdata <= PROVE_MAX |=> CFG.prove == $past(REQ.wdata))
        else $error("proving time not stored");

    lit_trial_a: assert property (
        !PILOT_TRIAL |=> !PILOT_LIT)
        else $error("pilot lit without trial");

    demand_on_a: assert property (
        CFG.demand == 16'h0001 && CFG.mode == MODE_AUTO |=> DEMAND_PILOT_ACTIVE)
        else $error("pilot on demand not active");

    mode_range_a: assert property (
        CFG.mode <= MODE_MAX)
        else $error("mode out of range");

    lockout_hold_a: assert property (
        HIGH_TEMP_LOCKOUT && !LOCKOUT_CLEAR |=> HIGH_TEMP_LOCKOUT)
        else $error("lockout dropped without clear");

    lockout_clear_a: assert property (
        HIGH_TEMP_LOCKOUT && LOCKOUT_CLEAR && !over_temp |=> !HIGH_TEMP_LOCKOUT)
        else $error("lockout not cleared");

    limit_range_a: assert property (
        $signed(CFG.limit) >= $signed(LIMIT_MIN) && $signed(CFG.limit) <= $signed(LIMIT_MAX))
        else $error("temperature limit out of range");

    src_none_a: assert property (
        CFG.p1_src == SRC_NONE |=> PROCESS1_VALUE == 16'h0000)
        else $error("process 1 value not zero for no source");

    prepurge_store_a: assert property (
        wr_req && REQ.addr == REG_PREPURGE && REQ.wdata <= PREPURGE_MAX |=> CFG.prepurge == $past(REQ.wdata))
        else $error("pre-purge time not stored");

    bad_addr_a: assert property (
        REQ.valid && REQ.addr > REG_LAST |=> RSP.valid && RSP.exc == EXC_ADDR && RSP.rdata == 16'h0000)
        else $error("unmapped register not refused");

    bad_data_a: assert property (
        wr_req && writable && !in_range |=> RSP.exc == EXC_DATA && $stable(CFG))
        else $error("out of range write stored");

    unused_write_a: assert property (
        wr_req && REQ.addr > REG_LIMIT && REQ.addr < REG_P1_SRC |=> RSP.exc == EXC_ADDR && $stable(CFG))
        else $error("unused register write not refused");

    ignite_write_c: cover property (wr_req && REQ.addr == REG_IGNITE ##1 RSP.exc == EXC_NONE);
    bad_write_c: cover property (wr_req && !in_range && writable ##1 RSP.exc == EXC_DATA);
    lockout_clear_c: cover property (HIGH_TEMP_LOCKOUT ##1 !HIGH_TEMP_LOCKOUT);
    pilot_lit_c: cover property ($rose(PILOT_LIT));
    demand_on_c: cover property ($rose(DEMAND_PILOT_ACTIVE));

endmodule // bcrb_reg_bank

// file: testbench/bcrb_bus_master.sv
// Purpose: fieldbus master model issuing single-word register requests
// Assumes: one request in flight, answer strobe raised by the taking edge and held for one cycle
// Notes: released address and data show the inverse of the last word
`timescale 1ns/1ps
module bcrb_bus_master import bcrb_pkg::*; (
    input logic CLK,
    output bcrb_req_t REQ,
    input bcrb_rsp_t RSP
);
    initial begin
        REQ = '0;
    end

    // --------------------------------------------------------------
    // one word transfer, bounded wait for the answer
    // --------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [7:0] e, output logic [15:0] r, output bit ok);
        int n;
        ok = 1'b0;
        e = 8'hff;
        r = 16'h0000;
        @(negedge CLK);
        REQ <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge CLK);
        REQ <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        for (n = 0; n < 4 && !ok; n++) begin
            if (RSP.valid === 1'b1) begin
                e = RSP.exc;
                r = RSP.rdata;
                ok = 1'b1;
            end else begin
                @(negedge CLK);
            end
        end
    endtask
endmodule // bcrb_bus_master

// file: testbench/tb_bcrb_reg_bank.sv
// Purpose: self-checking bench for the burner configuration register bank
// Assumes: inputs driven at the falling edge, TICKS shortened to 4
// Notes: identity parameters are arbitrary values
`timescale 1ns/1ps
module tb_bcrb_reg_bank;
    import bcrb_pkg::*;
    localparam logic [15:0] FWV = 16'h0a5c; // arbitrary value
    localparam logic [15:0] FWR = 16'h0003; // arbitrary value
    localparam logic [31:0] FCK = 32'h5a5ac3c3; // arbitrary value
    logic CLK, RST_N, trial, flame, lit, dem, lclr, lock;
    bcrb_req_t req;
    bcrb_rsp_t rsp;
    bcrb_cfg_t cfg;
    logic [15:0] tc1, tc2, tc3, tc4, pv;
    logic [15:0] rv [0:20] = '{16'h0000, FWV, FWR, FCK[31:16], FCK[15:0], 16'h0000, 16'h0005, 16'h001e,
        16'h000a, 16'h0000, 16'h0002, 16'h0002, 16'h0003, 16'h0000, 16'h0640, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0004};
    logic [15:0] wa [0:10] = '{16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000b,
        16'h000c, 16'h000d, 16'h000e, 16'h0014};
    logic [15:0] wm [0:10] = '{16'h0001, 16'h0258, 16'h003c, 16'h000a, 16'h0708, 16'h0003, 16'h0003,
        16'h0005, 16'h0001, 16'h099c, 16'h0004};
    logic [15:0] pe [0:4];
    int err_total = 0;
    int check_count = 0;
    int i, n;

    bcrb_reg_bank #(.FW_VERSION(FWV), .FW_REVISION(FWR), .FW_CHECKSUM(FCK), .TICKS(4)) u_dut (
        .CLK(CLK), .RST_N(RST_N), .REQ(req), .RSP(rsp), .CFG(cfg), .PILOT_TRIAL(trial),
        .FLAME_SENSED(flame), .PILOT_LIT(lit), .DEMAND_PILOT_ACTIVE(dem), .LOCKOUT_CLEAR(lclr),
        .HIGH_TEMP_LOCKOUT(lock), .FIRST_THERMOCOUPLE(tc1), .SECOND_THERMOCOUPLE(tc2),
        .BURNER_THERMOCOUPLE(tc3), .TRANSDUCER_INPUT(tc4), .PROCESS1_VALUE(pv));
    bcrb_bus_master u_master (.CLK(CLK), .REQ(req), .RSP(rsp));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // --------------------------------------------------------------
    // checking helpers
    // --------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] ee, input logic [15:0] er);
        logic [7:0] e;
        logic [15:0] r;
        bit ok;
        u_master.xfer(wr, a, d, e, r, ok);
        if (!ok) begin
            err_total++;
            $display("ERROR t=%0t no answer", $time);
            end_sim();
        end
        chk({8'h00, e}, ee);
        chk(r, er);
    endtask
    task automatic prove(output int cnt);
        trial = 1'b1;
        flame = 1'b1;
        for (cnt = 1; cnt < 40 && lit !== 1'b1; cnt++) begin
            @(negedge CLK);
        end
        if (cnt >= 40) begin
            err_total++;
            $display("ERROR t=%0t pilot never lit", $time);
            end_sim();
        end
    endtask

    initial begin
        RST_N = 1'b0;
        {trial, flame, lclr} = 3'h0;
        {tc1, tc2, tc3, tc4} = {16'h1111, 16'h2222, 16'hff00, 16'h4444};
        repeat (5) @(negedge CLK);
        RST_N = 1'b1;
        repeat (3) @(negedge CLK);
        for (i = 0; i < 21; i++) bus(1'b0, 16'(i), 16'h0000, 16'h0000, rv[i]);
        bus(1'b0, 16'h0015, 16'h0000, 16'h0002, 16'h0000);
        bus(1'b1, 16'h0001, 16'hffff, 16'h0002, 16'h0000);
        bus(1'b1, 16'h000f, 16'h0001, 16'h0002, 16'h0000);
        bus(1'b0, 16'h0001, 16'h0000, 16'h0000, FWV);
        for (i = 0; i < 11; i++) begin
            bus(1'b1, wa[i], wm[i], 16'h0000, wm[i]);
            bus(1'b1, wa[i], wm[i] + 16'h0001, 16'h0003, 16'h0000);
            bus(1'b0, wa[i], 16'h0000, 16'h0000, wm[i]);
        end
        chk(cfg.ignite, 16'h003c);
        chk(cfg.prepurge, 16'h0258);
        bus(1'b1, 16'h000e, 16'h0063, 16'h0003, 16'h0000);
        bus(1'b1, 16'h000e, 16'h0064, 16'h0000, 16'h0064);
        bus(1'b1, 16'h000e, 16'h099c, 16'h0000, 16'h099c);
        // pilot proving, one second of four ticks
        bus(1'b1, 16'h000c, 16'h0001, 16'h0000, 16'h0001);
        prove(n);
        chk(16'(n == 5 || n == 6), 16'h0001);
        flame = 1'b0;
        repeat (2) @(negedge CLK);
        chk({15'h0000, lit}, 16'h0000);
        bus(1'b1, 16'h000c, 16'h0000, 16'h0000, 16'h0000);
        prove(n);
        chk(16'(n <= 2), 16'h0001);
        // flame alone, without a trial, must not keep the pilot lit
        trial = 1'b0;
        repeat (2) @(negedge CLK);
        chk({15'h0000, lit}, 16'h0000);
        flame = 1'b0;
        // demand pilot only in automatic mode
        bus(1'b1, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
        @(negedge CLK);
        chk({15'h0000, dem}, 16'h0001);
        bus(1'b1, 16'h0005, 16'h0001, 16'h0000, 16'h0001);
        @(negedge CLK);
        chk({15'h0000, dem}, 16'h0000);
        // lockout against a limit of 2460, signed compare
        chk({15'h0000, lock}, 16'h0000);
        tc3 = 16'h099c;
        repeat (3) @(negedge CLK);
        chk({15'h0000, lock}, 16'h0000);
        tc3 = 16'h099d;
        @(negedge CLK);
        chk({15'h0000, lock}, 16'h0001);
        lclr = 1'b1;
        repeat (2) @(negedge CLK);
        chk({15'h0000, lock}, 16'h0001);
        tc3 = 16'h0064;
        repeat (2) @(negedge CLK);
        chk({15'h0000, lock}, 16'h0000);
        lclr = 1'b0;
        pe = '{16'h0000, tc1, tc2, tc3, tc4};
        for (i = 0; i < 5; i++) begin
            bus(1'b1, 16'h0014, 16'(i), 16'h0000, 16'(i));
            @(negedge CLK);
            chk(pv, pe[i]);
        end
        end_sim();
    end
endmodule // tb_bcrb_reg_bank
